// file: sasr_defs.svh
// Timing, width and reset constants for the static RAM host controller.
// Assumes a 250 MHz system clock; every count is derived from the ns figures.
`ifndef SASR_DEFS_SVH
`define SASR_DEFS_SVH

`define SASR_ADDR_W         15
`define SASR_DATA_W         8
`define SASR_DEPTH          32768
`define SASR_SYNC_STAGES    2
`define SASR_TIMER_W        3

`define SASR_CLK_NS         4
`define SASR_CYCLE_TIME_NS  12
`define SASR_ADDR_DATA_NS   12
`define SASR_OE_DATA_NS     6
`define SASR_ADDR_WEND_NS   10
`define SASR_DSETUP_NS      6
`define SASR_DESEL_FLOAT_NS 7
`define SASR_OE_FLOAT_NS    6

// Least times round up to whole cycles
`define SASR_CEIL_CYC(ns)   (((ns) + `SASR_CLK_NS - 1) / `SASR_CLK_NS)
`define SASR_MAX2(a, b)     (((a) > (b)) ? (a) : (b))

`define SASR_ACCESS_CYC     `SASR_MAX2(`SASR_CEIL_CYC(`SASR_ADDR_DATA_NS), \
                                       `SASR_CEIL_CYC(`SASR_OE_DATA_NS))
`define SASR_WRITE_CYC      `SASR_MAX2(`SASR_MAX2(`SASR_CEIL_CYC(`SASR_ADDR_WEND_NS), \
                                       `SASR_CEIL_CYC(`SASR_DSETUP_NS)), \
                                       `SASR_CEIL_CYC(`SASR_CYCLE_TIME_NS))
`define SASR_TURN_CYC       `SASR_MAX2(`SASR_CEIL_CYC(`SASR_DESEL_FLOAT_NS), \
                                       `SASR_CEIL_CYC(`SASR_OE_FLOAT_NS))

`define SASR_READ_LOAD      (`SASR_ACCESS_CYC + `SASR_SYNC_STAGES)
`define SASR_WRITE_LOAD     (`SASR_WRITE_CYC - 1)
`define SASR_TURN_LOAD      (`SASR_TURN_CYC - 1)

`define SASR_RST_ADDR       15'h0000
`define SASR_RST_DATA       8'h00

`endif

// file: sasr_host.sv
// Host controller driving an asynchronous 32K x 8 static RAM over its pins.
// Assumes the memory meets its own access and float limits; data in is async.
`timescale 1ns/1ns
`include "sasr_defs.svh"

module sasr_host
  import sasr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    req_valid,
  input  wire sasr_req_t               req,
  output      logic                    req_ready,
  output      logic                    rsp_valid,
  output      logic [`SASR_DATA_W-1:0] rsp_rdata,
  output      sasr_pin_out_t           pins,
  input  wire logic [`SASR_DATA_W-1:0] sram_dq_in
);

  sasr_state_t               state;
  sasr_state_t               next_state;
  sasr_pin_out_t             next_pins;
  logic                      next_req_ready;
  logic                      next_rsp_valid;
  logic [`SASR_DATA_W-1:0]   next_rsp_rdata;
  logic                      tmr_load;
  logic [`SASR_TIMER_W-1:0]  tmr_val;
  logic                      tmr_done;
  logic [`SASR_DATA_W-1:0]   dq_meta;
  logic [`SASR_DATA_W-1:0]   dq_sync;

  sasr_timer #(
    .W (`SASR_TIMER_W)
  ) u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // Read data arrives with no relation to clk
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_meta <= `SASR_RST_DATA;
      dq_sync <= `SASR_RST_DATA;
    end else begin
      dq_meta <= sram_dq_in;
      dq_sync <= dq_meta;
    end
  end

  always_comb begin
    next_state     = state;
    next_pins      = pins;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    tmr_load       = 1'b0;
    tmr_val        = '0;
    case (state)
      SASR_IDLE: begin
        if (req_valid && req_ready) begin
          tmr_load       = 1'b1;
          next_pins.addr = req.addr;
          next_pins.cs_n = 1'b0;
          if (req.write) begin
            // Output enable stays high so the memory never drives in a write
            next_pins.oe_n   = 1'b1;
            next_pins.we_n   = 1'b0;
            next_pins.dq_out = req.wdata;
            next_pins.dq_oe  = 1'b1;
            tmr_val          = `SASR_TIMER_W'(`SASR_WRITE_LOAD);
            next_state       = SASR_WRITE;
          end else begin
            next_pins.oe_n   = 1'b0;
            next_pins.we_n   = 1'b1;
            next_pins.dq_oe  = 1'b0;
            // Access time plus the two synchroniser stages
            tmr_val          = `SASR_TIMER_W'(`SASR_READ_LOAD);
            next_state       = SASR_READ;
          end
        end
      end
      SASR_READ: begin
        if (tmr_done) begin
          next_rsp_rdata = dq_sync;
          next_rsp_valid = 1'b1;
          next_pins.cs_n = 1'b1;
          next_pins.oe_n = 1'b1;
          tmr_load       = 1'b1;
          tmr_val        = `SASR_TIMER_W'(`SASR_TURN_LOAD);
          next_state     = SASR_TURN;
        end
      end
      SASR_WRITE: begin
        if (tmr_done) begin
          // Zero hold lets data release on the strobe edge itself
          next_pins.we_n  = 1'b1;
          next_pins.cs_n  = 1'b1;
          next_pins.dq_oe = 1'b0;
          next_rsp_valid  = 1'b1;
          next_state      = SASR_IDLE;
        end
      end
      SASR_TURN: begin
        // Idle gap until the memory has let go of the bus
        if (tmr_done) begin
          next_state = SASR_IDLE;
        end
      end
      default: begin
        next_state = SASR_IDLE;
      end
    endcase
    next_req_ready = (next_state == SASR_IDLE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state       <= SASR_IDLE;
      pins.addr   <= `SASR_RST_ADDR;
      pins.cs_n   <= 1'b1;
      pins.oe_n   <= 1'b1;
      pins.we_n   <= 1'b1;
      pins.dq_out <= `SASR_RST_DATA;
      pins.dq_oe  <= 1'b0;
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= `SASR_RST_DATA;
    end else begin
      state     <= next_state;
      pins      <= next_pins;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
    end
  end

  sequence seq_read_issue;
    $fell(pins.oe_n) && !pins.cs_n && pins.we_n;
  endsequence

  sequence seq_read_done;
    ##6 (rsp_valid && pins.oe_n && pins.cs_n);
  endsequence

  sequence seq_strobe_low;
    !pins.we_n [*3];
  endsequence

  chk_write_overlap: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.we_n |-> !pins.cs_n)
    else $error("write strobe low without select");

  chk_read_strobe_high: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.oe_n |-> pins.we_n)
    else $error("write strobe low during read");

  chk_read_latency: assert property (@(posedge clk) disable iff (sys_rst)
    seq_read_issue |-> seq_read_done)
    else $error("read answer not six cycles after enable");

  chk_addr_stable: assert property (@(posedge clk) disable iff (sys_rst)
    (!pins.cs_n && $past(!pins.cs_n)) |-> $stable(pins.addr))
    else $error("address moved while selected");

  chk_cycle_min: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins.cs_n) |-> !pins.cs_n [*3])
    else $error("cycle shorter than three clocks");

  chk_write_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins.we_n) |-> seq_strobe_low ##1 pins.we_n)
    else $error("write pulse not three clocks");

  chk_data_setup: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pins.we_n) |-> ($past(pins.dq_oe, 1) && $past(pins.dq_oe, 2) && !pins.dq_oe))
    else $error("write data setup or release wrong");

  chk_strobe_edges: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(pins.we_n) |-> $fell(pins.cs_n)) and ($rose(pins.we_n) |-> $rose(pins.cs_n)))
    else $error("strobe and select edges apart");

  chk_no_contention: assert property (@(posedge clk) disable iff (sys_rst)
    pins.dq_oe |-> pins.oe_n)
    else $error("host drives while memory output enabled");

  chk_turnaround: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pins.oe_n) |-> (!pins.dq_oe && !req_ready) [*2])
    else $error("bus turnaround too short");

endmodule : sasr_host

// file: sasr_mem_model.sv
// Behavioural 32K x 8 static RAM answering the host controller pins.
// Assumes the host drives pins on clock edges; returns the resolved bus level.
`timescale 1ns/1ns
`include "sasr_defs.svh"

module sasr_mem_model
  import sasr_pkg::*;
(
  input  wire logic                    slow,
  input  wire sasr_pin_out_t           pins,
  output      logic [`SASR_DATA_W-1:0] dq_level,
  output      logic                    clash
);
  logic [`SASR_DATA_W-1:0] mem [0:`SASR_DEPTH-1];
  logic [`SASR_DATA_W-1:0] drv_val;
  logic [`SASR_DATA_W-1:0] wr_val;
  logic [`SASR_ADDR_W-1:0] wr_addr;
  logic                    drv_on;
  logic                    rd_en;
  logic                    wr_en;

  initial begin
    for (int i = 0; i < `SASR_DEPTH; i++)
      mem[i] = i[7:0] ^ 8'h5A;
    drv_on  = 1'b0;
    drv_val = 8'h00;
  end

  // Strobe low or enable high keeps the outputs floating
  assign rd_en = !pins.cs_n && !pins.oe_n && pins.we_n;
  assign wr_en = !pins.cs_n && !pins.we_n;

  // Keep the last byte seen while strobing; host drops data on the closing edge
  always @(*) begin
    if (wr_en && pins.dq_oe) begin
      wr_val  = pins.dq_out;
      wr_addr = pins.addr;
    end
  end
  always @(negedge wr_en) mem[wr_addr] = wr_val;

  // Old data lingers, then a wrong pattern, then the stored byte
  always @(pins.addr or rd_en) begin
    if (rd_en) begin
      drv_on  <= #4 1'b1;
      drv_val <= #4 ~drv_val;
      drv_val <= #(slow ? 11 : 5) mem[pins.addr];
    end else begin
      drv_on <= #3 1'b0;
    end
  end

  // Floating bus shows the inverse so no stale byte is mistaken for data
  assign dq_level = pins.dq_oe ? pins.dq_out : (drv_on ? drv_val : ~drv_val);
  assign clash    = pins.dq_oe && drv_on;
endmodule : sasr_mem_model

// file: sasr_pkg.sv
// Types shared by the static RAM host controller and its timer.
// Assumes sasr_defs.svh supplies the widths.
`include "sasr_defs.svh"

package sasr_pkg;

  typedef enum logic [1:0] {
    SASR_IDLE  = 2'b00,
    SASR_READ  = 2'b01,
    SASR_WRITE = 2'b10,
    SASR_TURN  = 2'b11
  } sasr_state_t;

  typedef struct packed {
    logic                     write;
    logic [`SASR_ADDR_W-1:0]  addr;
    logic [`SASR_DATA_W-1:0]  wdata;
  } sasr_req_t;

  typedef struct packed {
    logic [`SASR_ADDR_W-1:0]  addr;
    logic                     cs_n;
    logic                     oe_n;
    logic                     we_n;
    logic [`SASR_DATA_W-1:0]  dq_out;
    logic                     dq_oe;
  } sasr_pin_out_t;

endpackage : sasr_pkg

// file: sasr_timer.sv
// Down counter that paces each phase of a memory cycle.
// Assumes a load pulse from the controller on the same clock.
`timescale 1ns/1ns

module sasr_timer
  import sasr_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output      logic         done
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == '0);

endmodule : sasr_timer

// file: tb_async_sram_read_write_timing.sv
// Self-checking bench for the static RAM host controller.
// Assumes sasr_mem_model stands on the memory side of the pins.
`timescale 1ns/1ns
`include "sasr_defs.svh"

module tb_async_sram_read_write_timing
  import sasr_pkg::*;
;
  logic                    clk;
  logic                    sys_rst;
  logic                    req_valid;
  sasr_req_t               req;
  logic                    req_ready;
  logic                    rsp_valid;
  logic [`SASR_DATA_W-1:0] rsp_rdata;
  sasr_pin_out_t           pins;
  logic [`SASR_DATA_W-1:0] dq_level;
  logic                    clash;
  logic                    slow;
  logic [`SASR_DATA_W-1:0] ref_mem [int];
  logic [`SASR_DATA_W-1:0] last_rd;
  logic [`SASR_ADDR_W-1:0] prev_addr;
  logic [`SASR_DATA_W-1:0] q_dat [$];
  logic                    q_wr [$];
  int                      q_cyc [$];
  int                      cyc;
  int                      hold;
  int                      fail_count;
  int                      samples_checked;

  sasr_host DUT (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
    .sram_dq_in(dq_level));
  sasr_mem_model u_mem (.slow(slow), .pins(pins), .dq_level(dq_level), .clash(clash));

  task automatic miss(input string msg);
    fail_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : miss

  task automatic report_and_stop;
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Holds the request until an edge samples ready high, then notes the answer
  task automatic issue(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req       <= '{write: wr, addr: a, wdata: d};
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (!wr)
      last_rd = ref_mem.exists(a) ? ref_mem[a] : (a[7:0] ^ 8'h5A);
    else
      ref_mem[a] = d;
    q_cyc.push_back(cyc);
    q_wr.push_back(wr);
    q_dat.push_back(last_rd);
  endtask : issue

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!sys_rst) begin
      samples_checked++;
      if (clash === 1'b1) miss("both sides drive the bus");
      if (pins.oe_n === 1'b0 && pins.we_n !== 1'b1) miss("strobe low in read");
      if (pins.we_n === 1'b0 && (pins.dq_oe !== 1'b1 || pins.cs_n !== 1'b0))
        miss("strobe alone");
      if (pins.addr !== prev_addr && hold < 2) miss("address changed too soon");
      hold      <= (pins.addr !== prev_addr) ? 0 : hold + 1;
      prev_addr <= pins.addr;
    end
    if (rsp_valid === 1'b1) begin
      if (q_cyc.size() == 0) begin
        miss("answer with nothing pending");
      end else begin
        // Pulse launched at take plus 3 or 6 is seen one edge later
        if (cyc - q_cyc[0] != (q_wr[0] ? 4 : 7)) miss("answer latency");
        if (rsp_rdata !== q_dat[0]) miss("read data");
        void'(q_cyc.pop_front());
        void'(q_wr.pop_front());
        void'(q_dat.pop_front());
      end
    end
  end

  initial begin
    repeat (6000) @(posedge clk);
    miss("watchdog expired");
    report_and_stop();
  end

  initial begin
    sys_rst   = 1'b1;
    req_valid = 1'b0;
    req       = '0;
    slow      = 1'b0;
    last_rd   = 8'h00;
    prev_addr = '0;
    cyc       = 0;
    hold      = 3;
    void'($urandom(32'h2cdfd8ed));
    repeat (20) @(posedge clk);
    samples_checked++;
    if (pins.cs_n !== 1'b1 || pins.we_n !== 1'b1 || pins.dq_oe !== 1'b0) miss("reset pins");
    sys_rst <= 1'b0;
    // Boundary addresses, back to back, then an unwritten place
    issue(1'b1, 15'h0000, 8'hFF);
    issue(1'b1, 15'h7FFF, 8'h00);
    issue(1'b0, 15'h0000, 8'h00);
    issue(1'b0, 15'h7FFF, 8'h00);
    issue(1'b0, 15'h1234, 8'h00);
    // Mixed traffic over a small window so reads meet earlier writes
    for (int i = 0; i < 80; i++) begin
      slow <= 1'($urandom % 2);
      issue(1'($urandom % 2), 15'h3FF8 + 15'($urandom % 8), 8'($urandom));
    end
    req_valid <= 1'b0;
    for (int i = 0; i < 20 && q_cyc.size() != 0; i++)
      @(posedge clk);
    samples_checked++;
    if (q_cyc.size() != 0) miss("answers missing");
    report_and_stop();
  end
endmodule : tb_async_sram_read_write_timing
